/* File: rtl/fsrs_pkg.sv */
/*
 * Constants shared by the flash resume and soft reset control block:
 * opcodes, status bit positions, register offsets and timing figures.
 * Assumes a 50 MHz system clock; times convert to cycles via ns_to_cyc.
 */
package fsrs_pkg;

	// ----------------------------------------------------------------
	// Serial opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_RESUME_A = 8'h7a;
	localparam logic [7:0] OP_RESUME_B = 8'h30;
	localparam logic [7:0] OP_RESET_ARM = 8'h66;
	localparam logic [7:0] OP_RESET_EXEC = 8'h99;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_READ_SECURITY = 8'h2b;

	// ----------------------------------------------------------------
	// Bit positions of the serial status and security bytes
	// ----------------------------------------------------------------
	localparam int STS_WIP_BIT = 0;
	localparam int STS_WEL_BIT = 1;
	localparam int SEC_PSB_BIT = 2;
	localparam int SEC_ESB_BIT = 3;

	// ----------------------------------------------------------------
	// Bus register map (byte addresses) and event bits
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_FLAGS = 4'h0;
	localparam logic [3:0] REG_EVENT = 4'h4;
	localparam logic [3:0] REG_MASK = 4'h8;
	localparam logic [3:0] REG_SECURITY = 4'hc;
	localparam int EV_W = 4;
	localparam logic [EV_W-1:0] EV_RESET_VAL = 4'h0;
	localparam int EV_RESUME = 0;
	localparam int EV_DONE = 1;
	localparam int EV_SRESET = 2;
	localparam int EV_ABORT = 3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int T_SETTLE_NS = 2000;
	localparam int T_RCV_PROG_NS = 1200;
	localparam int T_RCV_OTHER_NS = 400;
	localparam int CNT_W = 16;

	// Least time in ns to whole cycles, rounded up, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	typedef enum logic [2:0] {
		ST_SETTLE = 3'b000,
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_RECOVER = 3'b011
	} fsrs_state_t;

endpackage : fsrs_pkg

/* File: rtl/fsrs_link_if.sv */
/*
 * Carrier between the serial front end and the command controller.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface fsrs_link_if;
	logic fr_done;
	logic fr_ok;
	logic [7:0] fr_opcode;
	logic op_valid;
	logic tx_en;
	logic [7:0] tx_byte;

	modport rx (output fr_done, output fr_ok, output fr_opcode, output op_valid,
		input tx_en, input tx_byte);
	modport ctl (input fr_done, input fr_ok, input fr_opcode, input op_valid,
		output tx_en, output tx_byte);
endinterface : fsrs_link_if

/* File: rtl/fsrs_link_rx.sv */
/*
 * Serial front end: samples chip select, serial clock and data in on the
 * system clock, collects the opcode byte and reports the end of each frame that carried one.
 * Assumes the serial clock is well below a quarter of the system clock.
 */
`timescale 1ns/10ps
module fsrs_link_rx (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_si,
	output logic o_so,
	output logic o_so_oe_n,
	fsrs_link_if.rx lnk
);
	import fsrs_pkg::*;

	// ----------------------------------------------------------------
	// Three-stage synchronisers; a change counts when stages 2 and 3 agree
	// ----------------------------------------------------------------
	logic [2:0] cs_s, ck_s, si_s;
	logic cs_f, ck_f, si_f;
	wire cs_new = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_f;
	wire ck_new = (ck_s[1] == ck_s[2]) ? ck_s[2] : ck_f;
	wire si_new = (si_s[1] == si_s[2]) ? si_s[2] : si_f;
	wire cs_fall = cs_f & ~cs_new;
	wire cs_rise = ~cs_f & cs_new;
	wire ck_rise = ~ck_f & ck_new & ~cs_f;
	wire ck_fall = ck_f & ~ck_new & ~cs_f;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cs_s <= 3'h7;
			ck_s <= 3'h0;
			si_s <= 3'h0;
			cs_f <= 1'b1;
			ck_f <= 1'b0;
			si_f <= 1'b0;
		end else begin
			cs_s <= {cs_s[1:0], i_cs_n};
			ck_s <= {ck_s[1:0], i_sclk};
			si_s <= {si_s[1:0], i_si};
			cs_f <= cs_new;
			ck_f <= ck_new;
			si_f <= si_new;
		end
	end

	// ----------------------------------------------------------------
	// Opcode capture and frame end report
	// ----------------------------------------------------------------
	logic [7:0] shreg;
	logic [2:0] bit_cnt;
	logic got_op;
	wire [7:0] next_shreg = {shreg[6:0], si_new};

	// Only the first byte after select is decoded; the rest is counted
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			shreg <= 8'h00;
			bit_cnt <= 3'h0;
			got_op <= 1'b0;
			lnk.fr_opcode <= 8'h00;
			lnk.fr_done <= 1'b0;
			lnk.fr_ok <= 1'b0;
		end else begin
			lnk.fr_done <= cs_rise & got_op;
			lnk.fr_ok <= (bit_cnt == 3'h0);
			if (cs_fall) begin
				bit_cnt <= 3'h0;
				got_op <= 1'b0;
			end else if (ck_rise) begin
				shreg <= next_shreg;
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7 && !got_op) begin
					got_op <= 1'b1;
					lnk.fr_opcode <= next_shreg;
				end
			end
		end
	end

	assign lnk.op_valid = got_op & ~cs_f;

	// Read data leaves on the falling serial edge so it is stable at the rise
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_so <= 1'b0;
			o_so_oe_n <= 1'b1;
		end else if (cs_rise || cs_fall) begin
			o_so_oe_n <= 1'b1;
		end else if (ck_fall && got_op && lnk.tx_en) begin
			o_so <= lnk.tx_byte[3'h7 - bit_cnt];
			o_so_oe_n <= 1'b0;
		end
	end

endmodule : fsrs_link_rx

/* File: rtl/fsrs_ctrl.sv */
/*
 * Resume, two-step software reset and power-on control of a serial NOR
 * flash, with an Avalon-MM register slave and one level interrupt.
 * Assumes i_rst is the internal power-on reset and that program, erase and
 * suspend requests arrive as one-cycle pulses from the rest of the device.
 */
// The address map and the Avalon-MM register port were chosen for this implementation.
// Overview of operation
// - Resume restarts whichever program or erase is currently suspended.
// - Accepted resume sets write enable and busy, clears the matching suspend flag.
// - Resumed operation runs to completion unless suspended again or ended by software reset.
// - Completed software reset returns to standby with volatile state at defaults.
// - Reset execute acts only after a reset arm command.
// - Any other command between arm and execute cancels the arm.
// - Upper IO lines are ignored while arm and execute are received.
// - Software reset during program or erase aborts that operation.
// - Recovery after reset is longer when a program was interrupted.
// - After power-up the device is in standby with write enable cleared.
// - While power-on reset is held, logic is reset and commands ignored.
// - Arm and execute are accepted anytime during suspension, no latency wait.
// - Program and erase suspend flags are security bits 2 and 3.
`timescale 1ns/10ps
module fsrs_ctrl #(
	parameter int SETTLE_CYC = fsrs_pkg::ns_to_cyc(fsrs_pkg::T_SETTLE_NS),
	parameter int RCV_PROG_CYC = fsrs_pkg::ns_to_cyc(fsrs_pkg::T_RCV_PROG_NS),
	parameter int RCV_OTHER_CYC = fsrs_pkg::ns_to_cyc(fsrs_pkg::T_RCV_OTHER_NS)
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_sio0,
	input wire logic [2:0] i_upper_io_lines,
	output logic o_sio1,
	output logic o_sio1_oe_n,
	input wire logic i_wel_set,
	input wire logic i_prog_start,
	input wire logic i_erase_start,
	input wire logic i_suspend,
	input wire logic i_op_done,
	output logic o_op_run,
	output logic o_op_abort,
	output logic o_write_enable_latch,
	output logic o_write_in_progress,
	output logic o_program_suspend_flag,
	output logic o_erase_suspend_flag,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq
);
	import fsrs_pkg::*;

	fsrs_link_if lnk ();

	// The upper IO lines carry nothing this block needs
	wire unused_upper = ^i_upper_io_lines;

	fsrs_link_rx u_rx (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_cs_n(i_cs_n),
		.i_sclk(i_sclk),
		.i_si(i_sio0),
		.o_so(o_sio1),
		.o_so_oe_n(o_sio1_oe_n),
		.lnk(lnk.rx)
	);

	// ----------------------------------------------------------------
	// State and flags
	// ----------------------------------------------------------------
	fsrs_state_t state;
	logic [CNT_W-1:0] cnt;
	logic write_enable_latch, program_suspend_flag, erase_suspend_flag, armed, run_erase, nested_prog;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	wire frame_ok = lnk.fr_done & lnk.fr_ok;
	wire is_resume = (lnk.fr_opcode == OP_RESUME_A) || (lnk.fr_opcode == OP_RESUME_B);
	wire is_arm = lnk.fr_opcode == OP_RESET_ARM;
	wire is_exec = lnk.fr_opcode == OP_RESET_EXEC;
	wire live = (state == ST_IDLE) || (state == ST_RUN);
	wire resume_go = frame_ok & is_resume & (state == ST_IDLE) & (program_suspend_flag | erase_suspend_flag);
	wire sreset_go = frame_ok & is_exec & armed & live;
	wire busy_prog = (state == ST_RUN) & ~run_erase;
	wire [CNT_W-1:0] rcv_len = busy_prog ? CNT_W'(RCV_PROG_CYC) : CNT_W'(RCV_OTHER_CYC);
	wire op_done_go = (state == ST_RUN) & i_op_done;
	wire suspend_go = (state == ST_RUN) & i_suspend & ~nested_prog;
	wire abort_go = sreset_go & (state == ST_RUN);

	// Serial status and security bytes
	assign lnk.tx_byte = (lnk.fr_opcode == OP_READ_SECURITY) ?
		(8'(program_suspend_flag) << SEC_PSB_BIT) | (8'(erase_suspend_flag) << SEC_ESB_BIT) :
		(8'(write_enable_latch) << STS_WEL_BIT) | (8'(state != ST_IDLE) << STS_WIP_BIT);
	assign lnk.tx_en = lnk.op_valid & ((lnk.fr_opcode == OP_READ_STATUS) ||
		(lnk.fr_opcode == OP_READ_SECURITY));

	// ----------------------------------------------------------------
	// Main sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_SETTLE;
			cnt <= CNT_W'(SETTLE_CYC);
			write_enable_latch <= 1'b0;
			program_suspend_flag <= 1'b0;
			erase_suspend_flag <= 1'b0;
			run_erase <= 1'b0;
			nested_prog <= 1'b0;
		end else if (sreset_go) begin
			// Whatever ran is dropped; data in flight may be damaged
			state <= ST_RECOVER;
			cnt <= rcv_len;
			write_enable_latch <= 1'b0;
			program_suspend_flag <= 1'b0;
			erase_suspend_flag <= 1'b0;
			run_erase <= 1'b0;
			nested_prog <= 1'b0;
		end else begin
			case (state)
				ST_SETTLE, ST_RECOVER: begin
					// Only status and security reads are served while this counts down
					if (cnt == CNT_W'(1)) begin
						state <= ST_IDLE;
					end
					cnt <= cnt - CNT_W'(1);
				end
				ST_IDLE: begin
					if (i_wel_set) begin
						write_enable_latch <= 1'b1;
					end
					if (resume_go) begin
						state <= ST_RUN;
						write_enable_latch <= 1'b1;
						run_erase <= erase_suspend_flag;
						erase_suspend_flag <= 1'b0;
						program_suspend_flag <= program_suspend_flag & erase_suspend_flag;
					end else if (i_erase_start && !program_suspend_flag && !erase_suspend_flag) begin
						state <= ST_RUN;
						run_erase <= 1'b1;
					end else if (i_prog_start && !program_suspend_flag) begin
						state <= ST_RUN;
						run_erase <= 1'b0;
						nested_prog <= erase_suspend_flag;
					end
				end
				ST_RUN: begin
					// Runs until done or suspended, or until a software reset ends it
					if (op_done_go) begin
						state <= ST_IDLE;
						write_enable_latch <= 1'b0;
						nested_prog <= 1'b0;
					end else if (suspend_go) begin
						state <= ST_IDLE;
						write_enable_latch <= 1'b0;
						program_suspend_flag <= ~run_erase;
						erase_suspend_flag <= run_erase;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Arm latch: any other completed frame, broken or not, cancels it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			armed <= 1'b0;
		end else if (lnk.fr_done) begin
			armed <= frame_ok & is_arm & live;
		end
	end

	assign o_op_run = state == ST_RUN;
	assign o_op_abort = abort_go;
	assign o_write_enable_latch = write_enable_latch;
	assign o_write_in_progress = state != ST_IDLE;
	assign o_program_suspend_flag = program_suspend_flag;
	assign o_erase_suspend_flag = erase_suspend_flag;

	// ----------------------------------------------------------------
	// Events, mask and interrupt
	// ----------------------------------------------------------------
	logic [EV_W-1:0] ev, mask;
	logic ack;
	wire [EV_W-1:0] ev_in = {abort_go, sreset_go, op_done_go, resume_go};
	wire wr_go = i_avs_write & ack;
	wire [EV_W-1:0] ev_clr = (wr_go && i_avs_address == REG_EVENT) ?
		i_avs_writedata[EV_W-1:0] : '0;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ev <= EV_RESET_VAL;
			mask <= EV_RESET_VAL;
		end else begin
			ev <= (ev & ~ev_clr) | ev_in;
			if (wr_go && i_avs_address == REG_MASK) begin
				mask <= i_avs_writedata[EV_W-1:0];
			end
		end
	end

	assign o_irq = |(ev & mask);

	// ----------------------------------------------------------------
	// Avalon-MM slave: one wait cycle for every access
	// ----------------------------------------------------------------
	wire [31:0] flags_word = {26'h0, run_erase, armed, erase_suspend_flag, program_suspend_flag, write_enable_latch, state != ST_IDLE};
	// Built from the flags, not the serial byte, which follows the last opcode
	wire [31:0] sec_word = (32'(program_suspend_flag) << SEC_PSB_BIT) | (32'(erase_suspend_flag) << SEC_ESB_BIT);
	wire [31:0] next_rdata =
		(i_avs_address == REG_FLAGS) ? flags_word :
		(i_avs_address == REG_EVENT) ? {28'h0, ev} :
		(i_avs_address == REG_MASK) ? {28'h0, mask} :
		(i_avs_address == REG_SECURITY) ? sec_word :
		32'h0;

	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ack <= 1'b0;
			o_avs_readdata <= 32'h0;
		end else begin
			ack <= (i_avs_read | i_avs_write) & ~ack;
			if (i_avs_read && !ack) begin
				o_avs_readdata <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	resume_sets_wel_a: assert property (@(posedge i_clk) disable iff (i_rst)
		resume_go |=> write_enable_latch && o_write_in_progress && !erase_suspend_flag && (state == ST_RUN))
		else $error("resume did not set write enable and busy");

	resume_only_susp_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_op_run) && $past(frame_ok) && $past(is_resume) && !$past(i_prog_start)
		&& !$past(i_erase_start) |->
		$past(program_suspend_flag) || $past(erase_suspend_flag))
		else $error("resume started nothing that was suspended");

	run_until_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_op_run && !i_op_done && !i_suspend && !sreset_go |=> o_op_run)
		else $error("operation stopped without done or suspend");

	exec_needs_arm_a: assert property (@(posedge i_clk) disable iff (i_rst)
		frame_ok && is_exec && !armed |=> state != ST_RECOVER || $past(state) == ST_RECOVER)
		else $error("reset executed without arm");

	other_disarms_a: assert property (@(posedge i_clk) disable iff (i_rst)
		lnk.fr_done && !(frame_ok && is_arm) |=> !armed)
		else $error("arm survived another command");

	reset_clears_a: assert property (@(posedge i_clk) disable iff (i_rst)
		sreset_go |=> !write_enable_latch && !program_suspend_flag && !erase_suspend_flag && state == ST_RECOVER)
		else $error("software reset left volatile state");

	abort_on_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
		sreset_go && o_op_run |-> o_op_abort ##1 !o_op_run)
		else $error("running operation not aborted");

	recov_length_a: assert property (@(posedge i_clk) disable iff (i_rst)
		sreset_go |=> cnt == ($past(busy_prog) ? CNT_W'(RCV_PROG_CYC) :
		CNT_W'(RCV_OTHER_CYC)))
		else $error("recovery length does not match last operation");

	busy_in_recov_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(state == ST_SETTLE || state == ST_RECOVER) |-> o_write_in_progress && !resume_go
		&& !sreset_go)
		else $error("command taken during recovery");

	suspend_flags_a: assert property (@(posedge i_clk) disable iff (i_rst)
		lnk.tx_en && lnk.fr_opcode == OP_READ_SECURITY |->
		lnk.tx_byte[SEC_PSB_BIT] == program_suspend_flag && lnk.tx_byte[SEC_ESB_BIT] == erase_suspend_flag)
		else $error("security byte does not show suspend flags");

	irq_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
		|(ev_in & mask) && !(wr_go && i_avs_address == REG_MASK) |=> o_irq)
		else $error("unmasked event did not raise interrupt");

endmodule : fsrs_ctrl

/* File: tb/fsrs_host_model.sv */
/*
 * Host-side serial controller model: sends one frame of n clocks per go
 * pulse, opcode MSB first, and captures the read line on each clock.
 * Assumes i_clk is the 50 MHz system clock; the serial clock is 160 ns.
 */
`timescale 1ns/10ps
module fsrs_host_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [7:0] i_op,
	input wire logic [4:0] i_nbits,
	input wire logic i_so,
	input wire logic i_so_oe_n,
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_si,
	output logic o_busy,
	output logic [15:0] o_rx
);
	logic [7:0] sh;
	int n;
	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	// Clock stands low between frames; the released data line toggles
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_si = 1'b0;
		o_busy = 1'b0;
		o_rx = 16'h0;
		forever begin
			@(posedge i_clk);
			if (i_go === 1'b1) begin
				o_busy <= 1'b1;
				o_cs_n <= 1'b0;
				sh = i_op;
				n = i_nbits;
				repeat (4) @(posedge i_clk);
				for (int k = 0; k < n; k++) begin
					o_si <= sh[7];
					sh = {sh[6:0], sh[7]};
					repeat (4) @(posedge i_clk);
					o_sclk <= 1'b1;
					repeat (4) @(posedge i_clk);
					// Undriven read line never repeats its last value
					o_rx <= {o_rx[14:0], i_so_oe_n ? ~o_rx[0] : i_so};
					o_sclk <= 1'b0;
				end
				repeat (4) @(posedge i_clk);
				o_cs_n <= 1'b1;
				repeat (8) @(posedge i_clk);
				o_busy <= 1'b0;
			end else if (o_cs_n) begin
				o_si <= ~o_si;
			end
		end
	end
endmodule : fsrs_host_model

/* File: tb/fsrs_tb_top.sv */
/*
 * Bench of the resume and soft reset block: Avalon tasks, operation
 * pulses and serial frames sent through the host model.
 * Assumes the design package and the host model are compiled first.
 */
`timescale 1ns/10ps
module fsrs_tb_top;
	import fsrs_pkg::*;
	localparam int SET_C = 40;
	localparam int RP_C = 30;
	localparam int RO_C = 10;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [4:0] pls = 5'h0;
	logic [2:0] upper = 3'h0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic go = 1'b0;
	logic [7:0] op = 8'h0;
	logic [4:0] nb = 5'h8;
	logic cs_n, sclk, si, so, so_oe_n, busy, run, abort, write_enable_latch, write_in_progress, program_suspend_flag, erase_suspend_flag, wreq, irq;
	logic [15:0] rx;
	logic [31:0] rdat, d;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int rcv = 0;
	int aborts = 0;
	int t0, other_d;

	initial forever #10 i_clk = ~i_clk;

	// Upper lines churn all run long, recovery cycles and aborts counted
	always @(posedge i_clk) begin
		cyc++;
		upper <= upper + 3'h1;
		if (write_in_progress === 1'b1 && run === 1'b0) rcv++;
		if (abort === 1'b1) aborts++;
		if (cyc == 10000) begin
			n_errors++;
			results();
		end
	end

	fsrs_ctrl #(.SETTLE_CYC(SET_C), .RCV_PROG_CYC(RP_C), .RCV_OTHER_CYC(RO_C)) dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_sio0(si),
		.i_upper_io_lines(upper), .o_sio1(so), .o_sio1_oe_n(so_oe_n),
		.i_wel_set(pls[0]), .i_prog_start(pls[1]), .i_erase_start(pls[2]),
		.i_suspend(pls[3]), .i_op_done(pls[4]), .o_op_run(run), .o_op_abort(abort),
		.o_write_enable_latch(write_enable_latch), .o_write_in_progress(write_in_progress),
		.o_program_suspend_flag(program_suspend_flag), .o_erase_suspend_flag(erase_suspend_flag),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_irq(irq));

	fsrs_host_model host (.i_clk(i_clk), .i_go(go), .i_op(op), .i_nbits(nb), .i_so(so),
		.i_so_oe_n(so_oe_n), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si), .o_busy(busy),
		.o_rx(rx));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			n_errors++;
		end
	endtask : chk

	// Request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge i_clk);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wdat <= v;
		@(posedge i_clk iff wreq === 1'b0);
		d = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic rdx(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(d, e);
	endtask : rdx

	task automatic pulse(input int b);
		@(posedge i_clk);
		pls <= 5'h1 << b;
		@(posedge i_clk);
		pls <= 5'h0;
	endtask : pulse

	// Effects land about five cycles after select rises; seventeen are allowed
	task automatic frame(input logic [7:0] o, input logic [4:0] n);
		@(posedge i_clk);
		go <= 1'b1;
		op <= o;
		nb <= n;
		@(posedge i_clk);
		go <= 1'b0;
		@(posedge i_clk iff busy === 1'b0);
		repeat (8) @(posedge i_clk);
	endtask : frame

	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		pulse(1);
		chk(run, 1'b0);
		rdx(REG_FLAGS, 32'h1);
		repeat (SET_C + 8) @(posedge i_clk);
		rdx(REG_FLAGS, 32'h0);
		$display("test power_on done");
		bus(1'b1, REG_MASK, 32'h1);
		pulse(0);
		pulse(1);
		pulse(3);
		repeat (8) @(posedge i_clk);
		rdx(REG_SECURITY, 32'h4);
		frame(OP_RESUME_A, 5'd9);
		chk(program_suspend_flag, 1'b1);
		chk(irq, 1'b0);
		frame(OP_RESUME_A, 5'd8);
		rdx(REG_FLAGS, 32'h3);
		chk(irq, 1'b1);
		frame(OP_READ_STATUS, 5'd16);
		chk(rx[7:0], 8'h03);
		pulse(4);
		rdx(REG_FLAGS, 32'h0);
		rdx(REG_EVENT, 32'h3);
		bus(1'b1, REG_EVENT, 32'h1);
		repeat (2) @(posedge i_clk);
		chk(irq, 1'b0);
		rdx(REG_EVENT, 32'h2);
		rdx(4'h2, 32'h0);
		bus(1'b1, REG_MASK, 32'h0);
		$display("test program_resume done");
		// No program is started inside the erase suspension
		pulse(0);
		pulse(2);
		pulse(3);
		repeat (8) @(posedge i_clk);
		rdx(REG_SECURITY, 32'h8);
		frame(OP_READ_SECURITY, 5'd16);
		chk(rx[7:0], 8'h08);
		frame(OP_RESET_EXEC, 5'd8);
		chk(erase_suspend_flag, 1'b1);
		frame(OP_RESUME_B, 5'd8);
		rdx(REG_FLAGS, 32'h23);
		chk(irq, 1'b0);
		pulse(3);
		repeat (8) @(posedge i_clk);
		chk(erase_suspend_flag, 1'b1);
		frame(OP_RESET_ARM, 5'd8);
		t0 = rcv;
		frame(OP_RESET_EXEC, 5'd8);
		repeat (RP_C + 8) @(posedge i_clk);
		other_d = rcv - t0;
		rdx(REG_FLAGS, 32'h0);
		rdx(REG_EVENT, 32'h7);
		bus(1'b1, REG_EVENT, 32'hf);
		$display("test erase_resume_reset done");
		pulse(0);
		pulse(1);
		frame(OP_RESET_ARM, 5'd8);
		frame(OP_READ_STATUS, 5'd8);
		frame(OP_RESET_EXEC, 5'd8);
		chk(run, 1'b1);
		chk(32'(aborts), 32'h0);
		frame(OP_RESET_ARM, 5'd8);
		t0 = rcv;
		frame(OP_RESET_EXEC, 5'd8);
		repeat (RP_C + 8) @(posedge i_clk);
		chk(32'(aborts), 32'h1);
		chk(rcv - t0 > other_d, 1'b1);
		rdx(REG_FLAGS, 32'h0);
		rdx(REG_EVENT, 32'hc);
		$display("test reset_abort done");
		results();
	end
endmodule : fsrs_tb_top
